// >>> inc/dshp_defs.svh
// Constants for the sector header processor.
// Assumes a bit-serial disk stream with a bit clock; bytes are counted from it.
`ifndef DSHP_DEFS_SVH
`define DSHP_DEFS_SVH
// ----------------------------------------
// Commands (octal)
// ----------------------------------------
`define DSHP_CMD_FMT        6'o63
`define DSHP_CMD_WRDATA     6'o61
`define DSHP_CMD_RDHDR      6'o73
`define DSHP_CMD_RDDATA     6'o71
// ----------------------------------------
// Byte counts
// ----------------------------------------
`define DSHP_BC_SYNC_FMT    8'd39
`define DSHP_BC_RD_EN       8'd30
`define DSHP_BC_CYL_CMP     8'd2
`define DSHP_BC_ADR_CMP     8'd4
`define DSHP_BC_HDR_FOUND   8'd10
`define DSHP_BC_W1_END      8'd2
`define DSHP_BC_W2_END      8'd4
`define DSHP_BC_W3_END      8'd6
`define DSHP_BC_W4_END      8'd8
`define DSHP_BC_CRC_END     8'd10
// ----------------------------------------
// Data values
// ----------------------------------------
`define DSHP_SYNC_BYTE      8'h01
`define DSHP_CRC_INIT       16'hffff
`define DSHP_CRC_POLY       16'h1021
// ----------------------------------------
// APB map
// ----------------------------------------
`define DSHP_ADR_CTRL       12'h000
`define DSHP_ADR_DCYL       12'h004
`define DSHP_ADR_DSTK       12'h008
`define DSHP_ADR_STAT       12'h00c
`define DSHP_ADR_ERR1       12'h010
`define DSHP_ADR_HWORD      12'h014
`endif

// >>> inc/dshp_pkg.sv
// Types for the sector header processor.
// Assumes dshp_defs.svh for numeric constants.
package dshp_pkg;
  typedef enum logic [1:0] {DSHP_IDLE, DSHP_PRE, DSHP_HDR, DSHP_DONE} dshp_state_e;
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } dshp_apb_req_s;
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } dshp_apb_rsp_s;
endpackage

// >>> hw/dshp_top.sv
// Sector header processor: pre-header sync, five header words,
// compares, CRC check and header-found flag.
// Assumes DISK_* and controller clocks are asynchronous pins.
//
// Functional notes
// - Four commands: 63, 61, 73, 71
// - Format writes sync byte at 39
// - Load strobe after sync leaves register
// - Cylinder word: write clock before start, no sync clock
// - Format shifts out cylinder address
// - Sector/track word: sync clock, write clock
// - Format shifts out sector/track word
// - Key field sync clock fetches word four
// - Format shifts words three and four
// - CRC fifth word bypasses shift register
// - Reads deserialise cylinder into buffer
// - Cylinder compare at byte count 02
// - Reads deserialise sector/track into buffer
// - Full address compare at count 04
// - Key words passed, never examined
// - Read header: sync clock per word one to four, none for CRC word
// - CRC error sets bit, else found; read header finds even on error
// - Read header: found at count 10
// - Read enable set at count 30
// - Sync detect: header area, clear counter
`timescale 1ns/1ps
`include "dshp_defs.svh"
module dshp_top
  import dshp_pkg::*;
(
  input  wire logic          CORE_CLK,
  input  wire logic          RST,
  input  wire dshp_pkg::dshp_apb_req_s APB_REQ,
  output dshp_pkg::dshp_apb_rsp_s      APB_RSP,
  input  wire logic          DISK_SECTOR,
  input  wire logic          DISK_BIT_CLK,
  input  wire logic          DISK_RD_BIT,
  output logic               DISK_WR_BIT,
  output logic               DISK_WR_GATE,
  input  wire logic [15:0]   CTRL_DATA_IN,
  input  wire logic          CTRL_WRITE_CLOCK,
  output logic [15:0]        CTRL_DATA_OUT,
  output logic               SYNC_CLOCK_TO_CONTROLLER,
  output logic               SHIFT_REG_LOAD_STROBE,
  output logic               CYLINDER_MATCH,
  output logic               FULL_ADDRESS_MATCH,
  output logic               HEADER_FOUND
);
  import dshp_pkg::*;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [2:0] sec_s, bclk_s, wclk_s;
  logic [1:0] rbit_s;
  always_ff @(posedge CORE_CLK or posedge RST)
    if (RST)
    begin
      sec_s  <= 3'h0;
      bclk_s <= 3'h0;
      wclk_s <= 3'h0;
      rbit_s <= 2'h0;
    end
    else
    begin
      sec_s  <= {sec_s[1:0], DISK_SECTOR};
      bclk_s <= {bclk_s[1:0], DISK_BIT_CLK};
      wclk_s <= {wclk_s[1:0], CTRL_WRITE_CLOCK};
      rbit_s <= {rbit_s[0], DISK_RD_BIT};
    end
  // Controller word crosses by two stages, like its write clock
  logic [15:0] din_s1, din_s2;
  always_ff @(posedge CORE_CLK or posedge RST)
    if (RST)
    begin
      din_s1 <= 16'h0;
      din_s2 <= 16'h0;
    end
    else
    begin
      din_s1 <= CTRL_DATA_IN;
      din_s2 <= din_s1;
    end
  // Edges read only second and third stages
  logic sector_p, bit_p, wclk_p, rd_bit;
  assign sector_p = sec_s[1] & ~sec_s[2];
  assign bit_p    = bclk_s[1] & ~bclk_s[2];
  assign wclk_p   = wclk_s[1] & ~wclk_s[2];
  assign rd_bit   = rbit_s[1];

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [5:0]  cmd_q;
  logic        go_q;
  logic [9:0]  dcyl_q;
  logic [15:0] dstk_q;
  logic        header_crc_error_bit_err_q;
  logic [15:0] buf_q;
  logic        apb_acc;
  // Writes land only at the completing edge, never twice
  assign apb_acc = APB_REQ.psel & APB_REQ.penable & APB_RSP.pready;
  // Only the four sector commands start anything
  logic cmd_ok, fmt, rd_hdr, chk_crc;
  assign cmd_ok  = (cmd_q == `DSHP_CMD_FMT) | (cmd_q == `DSHP_CMD_WRDATA) |
                   (cmd_q == `DSHP_CMD_RDHDR) | (cmd_q == `DSHP_CMD_RDDATA);
  assign fmt     = cmd_q == `DSHP_CMD_FMT;
  assign rd_hdr  = cmd_q == `DSHP_CMD_RDHDR;
  assign chk_crc = (cmd_q == `DSHP_CMD_WRDATA) | (cmd_q == `DSHP_CMD_RDDATA);

  // ----------------------------------------
  // Byte timing
  // ----------------------------------------
  dshp_state_e st_q;
  logic [2:0]  bit_cnt_q;
  logic [7:0]  byte_cnt_q;
  logic        byte_p;
  logic [15:0] sr_q;
  logic        sr_bit_out;
  logic [15:0] crc_q;
  logic        rd_en_q, area_q;
  logic        sync_seen;
  assign byte_p = bit_p & (bit_cnt_q == 3'h7);
  assign sync_seen = rd_en_q & ~area_q & bit_p & ({sr_q[6:0], rd_bit} == `DSHP_SYNC_BYTE);

  always_ff @(posedge CORE_CLK or posedge RST)
    if (RST)
      bit_cnt_q <= 3'h0;
    else if (sector_p | sync_seen)
      bit_cnt_q <= 3'h0;
    else if (bit_p)
      bit_cnt_q <= bit_cnt_q + 3'h1;

  always_ff @(posedge CORE_CLK or posedge RST)
    if (RST)
      byte_cnt_q <= 8'h0;
    else if (sector_p | sync_seen)
      byte_cnt_q <= 8'h0;
    else if (fmt && st_q == DSHP_PRE && byte_p && byte_cnt_q == `DSHP_BC_SYNC_FMT)
      byte_cnt_q <= 8'h0;
    else if (byte_p)
      byte_cnt_q <= byte_cnt_q + 8'h1;

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_ff @(posedge CORE_CLK or posedge RST)
    if (RST)
      st_q <= DSHP_IDLE;
    else
      unique case (st_q)
        DSHP_IDLE: if (go_q && cmd_ok && sector_p) st_q <= DSHP_PRE;
        DSHP_PRE:
          if ((fmt && byte_p && byte_cnt_q == `DSHP_BC_SYNC_FMT) || sync_seen)
            st_q <= DSHP_HDR;
        DSHP_HDR: if (byte_p && byte_cnt_q == `DSHP_BC_CRC_END - 8'h1) st_q <= DSHP_DONE;
        DSHP_DONE: if (!go_q) st_q <= DSHP_IDLE;
      endcase

  logic in_hdr, word_end, hdr_word_end;
  assign in_hdr   = st_q == DSHP_HDR;
  assign word_end = byte_p & byte_cnt_q[0];
  assign hdr_word_end = in_hdr & word_end & (byte_cnt_q < `DSHP_BC_W4_END);

  always_ff @(posedge CORE_CLK or posedge RST)
    if (RST)
      rd_en_q <= 1'b0;
    else if (st_q == DSHP_IDLE)
      rd_en_q <= 1'b0;
    else if (!fmt && st_q == DSHP_PRE && byte_p && byte_cnt_q == `DSHP_BC_RD_EN - 8'h1)
      rd_en_q <= 1'b1;

  always_ff @(posedge CORE_CLK or posedge RST)
    if (RST)
      area_q <= 1'b0;
    else if (st_q == DSHP_IDLE)
      area_q <= 1'b0;
    else if (sync_seen)
      area_q <= 1'b1;

  // ----------------------------------------
  // Shift register and CRC
  // ----------------------------------------
  logic load_sr;
  // load after sync, then per word
  assign load_sr = fmt & ((st_q == DSHP_PRE && byte_p && byte_cnt_q == `DSHP_BC_SYNC_FMT) |
                          (in_hdr && word_end && byte_cnt_q < `DSHP_BC_W4_END - 8'h1));
  assign sr_bit_out = sr_q[15];
  logic crc_phase;
  assign crc_phase = in_hdr & (byte_cnt_q >= `DSHP_BC_W4_END);

  always_ff @(posedge CORE_CLK or posedge RST)
    if (RST)
      sr_q <= 16'h0;
    else if (sector_p)
      sr_q <= 16'h0;
    else if (fmt && st_q == DSHP_PRE && bit_p && byte_cnt_q == `DSHP_BC_SYNC_FMT - 8'h1 &&
             bit_cnt_q == 3'h7)
      sr_q <= {`DSHP_SYNC_BYTE, 8'h00};
    else if (load_sr)
      sr_q <= buf_q;
    else if (bit_p)
      sr_q <= {sr_q[14:0], fmt ? 1'b0 : rd_bit};

  logic crc_in, crc_fb;
  assign crc_in = fmt ? sr_bit_out : rd_bit;
  assign crc_fb = crc_q[15] ^ crc_in;
  always_ff @(posedge CORE_CLK or posedge RST)
    if (RST)
      crc_q <= `DSHP_CRC_INIT;
    else if (st_q != DSHP_HDR)
      crc_q <= `DSHP_CRC_INIT;
    else if (bit_p && fmt && crc_phase)
      crc_q <= {crc_q[14:0], 1'b0};
    else if (bit_p)
      crc_q <= {crc_q[14:0], 1'b0} ^ (crc_fb ? `DSHP_CRC_POLY : 16'h0);

  always_ff @(posedge CORE_CLK or posedge RST)
    if (RST)
    begin
      DISK_WR_BIT  <= 1'b0;
      DISK_WR_GATE <= 1'b0;
    end
    else
    begin
      DISK_WR_GATE <= fmt & (st_q == DSHP_PRE | in_hdr);
      DISK_WR_BIT  <= crc_phase ? crc_q[15] : sr_bit_out;
    end

  // ----------------------------------------
  // Data buffer and controller handshake
  // ----------------------------------------
  // key words buffered, not examined
  always_ff @(posedge CORE_CLK or posedge RST)
    if (RST)
      buf_q <= 16'h0;
    else if (fmt && wclk_p)
      buf_q <= din_s2;
    else if (!fmt && hdr_word_end)
      buf_q <= {sr_q[14:0], rd_bit};

  always_ff @(posedge CORE_CLK or posedge RST)
    if (RST)
      SYNC_CLOCK_TO_CONTROLLER <= 1'b0;
    else
      SYNC_CLOCK_TO_CONTROLLER <= (fmt & in_hdr & byte_p & ~byte_cnt_q[0] &
                                   (byte_cnt_q < `DSHP_BC_W3_END)) |
                                  (rd_hdr & hdr_word_end);

  always_ff @(posedge CORE_CLK or posedge RST)
    if (RST)
    begin
      SHIFT_REG_LOAD_STROBE <= 1'b0;
      CTRL_DATA_OUT         <= 16'h0;
    end
    else
    begin
      SHIFT_REG_LOAD_STROBE <= load_sr;
      CTRL_DATA_OUT         <= buf_q;
    end

  // ----------------------------------------
  // Compares and header found
  // ----------------------------------------
  logic cmp_edge;
  assign cmp_edge = !fmt & in_hdr & byte_p;
  always_ff @(posedge CORE_CLK or posedge RST)
    if (RST)
    begin
      CYLINDER_MATCH     <= 1'b0;
      FULL_ADDRESS_MATCH <= 1'b0;
    end
    else if (sector_p)
    begin
      CYLINDER_MATCH     <= 1'b0;
      FULL_ADDRESS_MATCH <= 1'b0;
    end
    else if (cmp_edge && byte_cnt_q == `DSHP_BC_CYL_CMP - 8'h1)
      CYLINDER_MATCH <= {sr_q[14:0], rd_bit} == {6'h00, dcyl_q};
    else if (cmp_edge && byte_cnt_q == `DSHP_BC_ADR_CMP - 8'h1)
      FULL_ADDRESS_MATCH <= CYLINDER_MATCH & ({sr_q[14:0], rd_bit} == dstk_q);

  logic crc_end, crc_good;
  assign crc_end  = !fmt & in_hdr & byte_p & (byte_cnt_q == `DSHP_BC_HDR_FOUND - 8'h1);
  assign crc_good = ({crc_q[14:0], 1'b0} ^ (crc_fb ? `DSHP_CRC_POLY : 16'h0)) == 16'h0;
  always_ff @(posedge CORE_CLK or posedge RST)
    if (RST)
      HEADER_FOUND <= 1'b0;
    else if (sector_p)
      HEADER_FOUND <= 1'b0;
    else if (crc_end && (rd_hdr || (chk_crc && crc_good)))
      HEADER_FOUND <= 1'b1;

  logic err_clr;
  assign err_clr = apb_acc & APB_REQ.pwrite & (APB_REQ.paddr == `DSHP_ADR_ERR1) & APB_REQ.pwdata[0];
  always_ff @(posedge CORE_CLK or posedge RST)
    if (RST)
      header_crc_error_bit_err_q <= 1'b0;
    else if (crc_end && (chk_crc || rd_hdr) && !crc_good)
      header_crc_error_bit_err_q <= 1'b1;
    else if (err_clr)
      header_crc_error_bit_err_q <= 1'b0;

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  always_ff @(posedge CORE_CLK or posedge RST)
    if (RST)
    begin
      cmd_q  <= 6'h0;
      go_q   <= 1'b0;
      dcyl_q <= 10'h0;
      dstk_q <= 16'h0;
    end
    else if (apb_acc && APB_REQ.pwrite)
      unique case (APB_REQ.paddr)
        `DSHP_ADR_CTRL:
        begin
          cmd_q <= APB_REQ.pwdata[5:0];
          go_q  <= APB_REQ.pwdata[8];
        end
        `DSHP_ADR_DCYL: dcyl_q <= APB_REQ.pwdata[9:0];
        `DSHP_ADR_DSTK: dstk_q <= APB_REQ.pwdata[15:0];
        default: ;
      endcase

  logic [31:0] rd_d;
  logic        err_d;
  always_comb
  begin
    rd_d  = 32'h0;
    err_d = 1'b0;
    unique case (APB_REQ.paddr)
      `DSHP_ADR_CTRL: rd_d = {23'h0, go_q, 2'h0, cmd_q};
      `DSHP_ADR_DCYL: rd_d = {22'h0, dcyl_q};
      `DSHP_ADR_DSTK: rd_d = {16'h0, dstk_q};
      `DSHP_ADR_STAT: rd_d = {25'h0, area_q, rd_en_q, HEADER_FOUND, FULL_ADDRESS_MATCH,
                              CYLINDER_MATCH, st_q};
      `DSHP_ADR_ERR1: rd_d = {31'h0, header_crc_error_bit_err_q};
      `DSHP_ADR_HWORD: rd_d = {16'h0, buf_q};
      default: err_d = 1'b1;
    endcase
  end

  // Registered answer: one wait state keeps prdata off a long path
  always_ff @(posedge CORE_CLK or posedge RST)
    if (RST)
      APB_RSP <= '0;
    else if (APB_REQ.psel && APB_REQ.penable && !APB_RSP.pready)
    begin
      APB_RSP.pready  <= 1'b1;
      APB_RSP.prdata  <= rd_d;
      APB_RSP.pslverr <= err_d;
    end
    else
      APB_RSP <= '0;
endmodule

// >>> test/dshp_monitor.sv
// Checker on the header processor's top ports.
// Assumes one clock domain and the active-high reset.
`timescale 1ns/1ps
module dshp_top_monitor
  import dshp_pkg::*;
(
  input wire logic                    CORE_CLK,
  input wire logic                    RST,
  input wire dshp_pkg::dshp_apb_rsp_s APB_RSP,
  input wire logic                    DISK_SECTOR,
  input wire logic                    DISK_WR_GATE,
  input wire logic                    SYNC_CLOCK_TO_CONTROLLER,
  input wire logic                    SHIFT_REG_LOAD_STROBE,
  input wire logic                    CYLINDER_MATCH,
  input wire logic                    FULL_ADDRESS_MATCH,
  input wire logic                    HEADER_FOUND
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  // ----------------------------------------
  // Sequences
  // ----------------------------------------
  sequence s_sector;
    $rose(DISK_SECTOR);
  endsequence
  sequence s_cleared;
    !CYLINDER_MATCH && !FULL_ADDRESS_MATCH && !HEADER_FOUND;
  endsequence
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_clear;
    s_sector |-> ##[1:6] s_cleared;
  endproperty
  a_clear: assert property (p_clear) else $error("flags not cleared by sector pulse");
  property p_cyl_hold;
    $rose(CYLINDER_MATCH) |=> CYLINDER_MATCH [*8];
  endproperty
  a_cyl_hold: assert property (p_cyl_hold) else $error("cylinder match dropped");
  property p_full_cyl;
    FULL_ADDRESS_MATCH |-> CYLINDER_MATCH;
  endproperty
  a_full_cyl: assert property (p_full_cyl) else $error("full match without cylinder");
  property p_found_hold;
    $rose(HEADER_FOUND) |=> HEADER_FOUND [*8];
  endproperty
  a_found_hold: assert property (p_found_hold) else $error("header found dropped");
  property p_found_read;
    $rose(HEADER_FOUND) |-> !DISK_WR_GATE;
  endproperty
  a_found_read: assert property (p_found_read) else $error("header found while writing");
  property p_sync_pulse;
    SYNC_CLOCK_TO_CONTROLLER |=> !SYNC_CLOCK_TO_CONTROLLER;
  endproperty
  a_sync_pulse: assert property (p_sync_pulse) else $error("sync clock too long");
  property p_strobe_pulse;
    SHIFT_REG_LOAD_STROBE |=> !SHIFT_REG_LOAD_STROBE;
  endproperty
  a_strobe_pulse: assert property (p_strobe_pulse) else $error("load strobe too long");
  property p_strobe_gate;
    SHIFT_REG_LOAD_STROBE |-> DISK_WR_GATE;
  endproperty
  a_strobe_gate: assert property (p_strobe_gate) else $error("load strobe outside write");
  property p_pready;
    APB_RSP.pready |=> !APB_RSP.pready;
  endproperty
  a_pready: assert property (p_pready) else $error("pready longer than one cycle");
endmodule
bind dshp_top dshp_top_monitor dshp_top_monitor_inst (.CORE_CLK, .RST, .APB_RSP, .DISK_SECTOR, .DISK_WR_GATE,
  .SYNC_CLOCK_TO_CONTROLLER, .SHIFT_REG_LOAD_STROBE, .CYLINDER_MATCH, .FULL_ADDRESS_MATCH, .HEADER_FOUND);

// >>> test/dshp_ctrl_model.sv
// Controller model: answers sync clocks with words, captures read words.
// Assumes the device's sync clock is a one-cycle pulse.
`timescale 1ns/1ps
module dshp_ctrl_model #(parameter int DLY = 3)
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        sync,
  input  wire logic        push,
  input  wire logic        answer,
  input  wire logic [63:0] words,
  input  wire logic [15:0] dout,
  output logic             wclk,
  output logic [15:0]      din,
  output logic [63:0]      rx
);
  logic [3:0] cnt_q;
  logic [1:0] idx_q;
  logic       cap_q;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      {cnt_q, idx_q, wclk, din} <= '0;
    end
    else if (cnt_q != 4'h0)
    begin
      cnt_q <= cnt_q + 4'h1;
      if (cnt_q == DLY)
        din <= words[63 - 16 * idx_q -: 16];
      if (cnt_q == DLY + 1)
        wclk <= 1'b1;
      // Released data flips so stale bits never look valid
      if (cnt_q == DLY + 7)
      begin
        wclk  <= 1'b0;
        din   <= ~din;
        cnt_q <= 4'h0;
        idx_q <= idx_q + 2'h1;
      end
    end
    else if (push || (sync && answer))
    begin
      cnt_q <= 4'h1;
      if (push)
        idx_q <= 2'h0;
    end
  end
  always_ff @(posedge clk)
  begin
    cap_q <= sync;
    if (cap_q)
      rx <= {rx[47:0], dout};
  end
endmodule

// >>> test/dshp_top_tb.sv
// Testbench for the sector header processor.
// Assumes a free-running bit clock of eight core cycles.
`timescale 1ns/1ps
`include "dshp_defs.svh"
module dshp_top_tb;
  import dshp_pkg::*;
  logic          clk = 0, rst = 1, sector = 0, rd_bit = 0, push = 0, answer = 0;
  logic [2:0]    bc = 0;
  dshp_apb_req_s req = '0;
  dshp_apb_rsp_s rsp;
  logic          wr_bit, gate, wclk, sync, strobe, cyl, full, found;
  logic [15:0]   din, dout;
  logic [63:0]   words = '0, rx;
  int            mismatches = 0, n_checks = 0;
  always #2.5 clk = ~clk;
  always_ff @(posedge clk) bc <= bc + 3'h1;
  dshp_top dshp_top_inst (.CORE_CLK(clk), .RST(rst), .APB_REQ(req), .APB_RSP(rsp), .DISK_SECTOR(sector),
    .DISK_BIT_CLK(bc[2]), .DISK_RD_BIT(rd_bit), .DISK_WR_BIT(wr_bit), .DISK_WR_GATE(gate), .CTRL_DATA_IN(din),
    .CTRL_WRITE_CLOCK(wclk), .CTRL_DATA_OUT(dout), .SYNC_CLOCK_TO_CONTROLLER(sync),
    .SHIFT_REG_LOAD_STROBE(strobe), .CYLINDER_MATCH(cyl), .FULL_ADDRESS_MATCH(full), .HEADER_FOUND(found));
  dshp_ctrl_model dshp_ctrl_model_inst (.clk(clk), .rst(rst), .sync(sync), .push(push), .answer(answer),
    .words(words), .dout(dout), .wclk(wclk), .din(din), .rx(rx));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task stop_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, exp, got);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk);
    req.penable <= 1'b1;
    do @(posedge clk); while (rsp.pready !== 1'b1);
    r = rsp.prdata;
    e = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    @(posedge clk);
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask
  task put_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
    begin
      do @(posedge clk); while (bc !== 3'h0);
      rd_bit <= b[i];
    end
  endtask
  task pulse();
    sector <= 1'b1;
    repeat (4) @(posedge clk);
    sector <= 1'b0;
  endtask
  function automatic logic [15:0] crc(input logic [63:0] d);
    logic [15:0] c;
    c = `DSHP_CRC_INIT;
    for (int i = 63; i >= 0; i--)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? `DSHP_CRC_POLY : 16'h0);
    return c;
  endfunction
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Header stream with optional CRC damage, then flag checks
  task run_read(input logic [5:0] cmd, input logic [63:0] w, input logic [15:0] bad, input logic [3:0] e);
    logic [15:0] c;
    logic [31:0] r;
    logic        s;
    wr(`DSHP_ADR_CTRL, {23'h0, 1'b1, 2'h0, cmd});
    pulse();
    repeat (34) put_byte(8'h00);
    put_byte(`DSHP_SYNC_BYTE);
    for (int k = 0; k < 8; k++)
      put_byte(w[63 - 8 * k -: 8]);
    c = crc(w) ^ bad;
    put_byte(c[15:8]);
    put_byte(c[7:0]);
    repeat (3) put_byte(8'h00);
    chk("cyl", 32'(cyl), 32'(e[3]));
    chk("full", 32'(full), 32'(e[2]));
    chk("found", 32'(found), 32'(e[1]));
    apb(1'b0, `DSHP_ADR_ERR1, 32'h0, r, s);
    chk("err1", r, 32'(e[0]));
    wr(`DSHP_ADR_ERR1, 32'h1);
    wr(`DSHP_ADR_CTRL, 32'h0);
  endtask
  task run_format(input logic [63:0] w);
    logic        q[$];
    logic [79:0] x;
    int          i;
    // Buffer takes the first word only once the format command is armed
    wr(`DSHP_ADR_CTRL, {23'h0, 1'b1, 2'h0, `DSHP_CMD_FMT});
    words  <= w;
    answer <= 1'b1;
    push   <= 1'b1;
    @(posedge clk);
    push <= 1'b0;
    repeat (20) @(posedge clk);
    // Fixed bit phase so the first gated sample is bit zero
    do @(posedge clk); while (bc !== 3'h5);
    pulse();
    for (int n = 0; n < 480; n++)
    begin
      do @(posedge clk); while (bc !== 3'h3);
      if (gate === 1'b1)
        q.push_back(wr_bit);
    end
    i = 0;
    while (i < q.size() - 81 && q[i] !== 1'b1)
      i++;
    for (int j = 0; j < 80; j++)
      x = {x[78:0], q[i + 1 + j]};
    chk("sync_pos", i, 319);
    chk("fmt_w12", x[79:48], w[63:32]);
    chk("fmt_w34", x[47:16], w[31:0]);
    chk("fmt_crc", {16'h0, x[15:0]}, {16'h0, crc(w)});
    answer <= 1'b0;
    wr(`DSHP_ADR_CTRL, 32'h0);
  endtask
  task run_regs();
    logic [31:0] r;
    logic        e;
    wr(`DSHP_ADR_DCYL, 32'h155);
    wr(`DSHP_ADR_DSTK, 32'h0a07);
    apb(1'b0, `DSHP_ADR_DCYL, 32'h0, r, e);
    chk("dcyl", r, 32'h155);
    apb(1'b0, 12'h0f0, 32'h0, r, e);
    chk("slverr", 32'(e), 32'h1);
  endtask
  initial
  begin
    #200000;
    mismatches++;
    stop_test();
  end
  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    run_regs();
    run_read(`DSHP_CMD_RDDATA, 64'h0155_0a07_1234_5678, 16'h0, 4'b1110);
    run_read(`DSHP_CMD_RDDATA, 64'h0155_0a07_0000_ffff, 16'h0040, 4'b1101);
    run_read(`DSHP_CMD_RDHDR, 64'h0155_0a07_abcd_0001, 16'h8000, 4'b1111);
    chk("rx_hi", rx[63:32], 32'h0155_0a07);
    chk("rx_lo", rx[31:0], 32'habcd_0001);
    run_read(`DSHP_CMD_WRDATA, 64'h0154_0a07_5555_aaaa, 16'h0, 4'b0010);
    run_read(`DSHP_CMD_WRDATA, 64'h0155_0a06_5555_aaaa, 16'h0, 4'b1010);
    run_read(6'o77, 64'h0155_0a07_1234_5678, 16'h0, 4'b0000);
    run_format(64'h0155_0a07_c3c3_0f0f);
    stop_test();
  end
endmodule
